// ===== rtl/lrc_pkg.sv
/*
 * Shared types and constants for one logic cluster: ten cells with
 * their register controls, the cell chains and the row and column
 * segment selectors.
 * Assumes the user keeps every configuration port static while the
 * cluster runs.
 */
`default_nettype none
package lrc_pkg;

    // Cells in a cluster, numbered 0..9 in code
    localparam int NUM_CELLS = 10;
    localparam int IDX_W = 4;
    localparam int LUT_IN = 4;
    localparam int LUT_SIZE = 16;

    // Fixed reach of the segments, in blocks
    localparam int ROW_SPAN_CLUSTERS = 4;
    localparam int ROW_SPAN_MIXED_CLUSTERS = 2;
    localparam int ROW_SPAN_MIXED_MEMORIES = 1;
    localparam int COL_SPAN_ROWS = 4;

    // Control lines shared by the cluster
    localparam int NUM_CLEARS = 2;
    localparam int NUM_PRESETS = 1;

    // Register reset value
    localparam logic REG_RESET = 1'b0;
    localparam logic PRESET_LEVEL = 1'b1;

    // Which shared clear a cell listens to
    typedef enum logic [1:0] {
        CLR_NONE = 2'b00,
        CLR_A = 2'b01,
        CLR_B = 2'b10,
        CLR_BOTH = 2'b11
    } lrc_clr_sel_t;

    // Sources that may drive a row segment
    typedef enum logic [1:0] {
        ROW_OWN = 2'b00,
        ROW_NEIGHBOUR = 2'b01,
        ROW_EXTEND = 2'b10,
        ROW_FROM_COL = 2'b11
    } lrc_row_src_t;

    // Sources that may drive a column segment
    typedef enum logic [1:0] {
        COL_OWN = 2'b00,
        COL_NEIGHBOUR = 2'b01,
        COL_EXTEND = 2'b10,
        COL_FROM_ROW = 2'b11
    } lrc_col_src_t;

    // Per-cell configuration
    typedef struct packed {
        logic [LUT_SIZE-1:0] lut_mask;
        logic fast_from_chain;
        logic reg_from_chain;
        lrc_clr_sel_t clr_sel;
        logic preset_use;
        logic aload_data;
    } lrc_cell_cfg_t;

    // Cluster-wide register controls
    typedef struct packed {
        logic [NUM_CLEARS-1:0] aclr;
        logic apre;
        logic sclr;
        logic sload;
        logic ena;
    } lrc_ctrl_t;

    // Routing configuration of the cluster
    typedef struct packed {
        lrc_row_src_t row_right_src;
        lrc_row_src_t row_left_src;
        lrc_col_src_t col_src;
        logic col_down;
        logic [IDX_W-1:0] row_cell;
        logic [IDX_W-1:0] col_cell;
        logic [IDX_W-1:0] link_left_cell;
        logic [IDX_W-1:0] link_right_cell;
        logic link_from_right;
        logic clkgen_sel;
    } lrc_route_cfg_t;

endpackage : lrc_pkg
`default_nettype wire

// ===== rtl/lrc_cluster.sv
/*
 * One logic cluster: ten cells with register clear, preset and load,
 * the combinational and register chains, direct links and the row and
 * column segment drivers.
 * Assumes one clock, synchronous reset rstn, and that configuration
 * ports stay constant in operation. Neighbours are plain wires.
 */
`timescale 1ns/10ps
`default_nettype none

module lrc_cluster #(
    parameter bit DEV_RESET_EN = 1'b1 // Static option for the pin
) (
    input wire logic clk, // 125 MHz clock
    input wire logic rstn, // Synchronous reset, active low
    input wire logic device_wide_reset_n, // Chip-wide reset pin
    input wire lrc_pkg::lrc_ctrl_t ctrl, // Shared register controls
    input wire lrc_pkg::lrc_cell_cfg_t [9:0] cell_cfg, // Per-cell setup
    input wire lrc_pkg::lrc_route_cfg_t route_cfg, // Routing setup
    input wire logic [9:0][3:0] cell_data, // Four data inputs per cell
    input wire logic lut_chain_in, // Chain from cell above cluster
    input wire logic reg_chain_in, // Register chain into cell one
    input wire logic direct_from_left, // Direct link from left block
    input wire logic direct_from_right, // Direct link from right block
    input wire logic clkgen_in, // Clock generator, left side
    input wire logic row_right_nbr, // Right neighbour onto rightward
    input wire logic row_left_nbr, // Left neighbour onto leftward
    input wire logic row_right_in, // Arriving rightward segment
    input wire logic row_left_in, // Arriving leftward segment
    input wire logic col_nbr, // Neighbour onto column segment
    input wire logic col_in, // Arriving column segment
    output logic [9:0] comb_out, // Combinational cell outputs
    output logic [9:0] reg_out, // Register cell outputs
    output logic lut_chain_out, // Chain to cluster below
    output logic reg_chain_out, // Register chain to next cluster
    output logic direct_left_out, // Into left neighbour local
    output logic direct_right_out, // Into right neighbour local
    output logic row_right_out, // Rightward row segment
    output logic row_left_out, // Leftward row segment
    output logic col_up_out, // Upward column segment
    output logic col_down_out // Downward column segment
);

    // Pick one cell's bit; an index past the last cell gives zero, so a
    // selector left at a spare code reads a quiet low instead of an X
    function automatic logic pick_cell(input logic [9:0] vec,
                                       input logic [3:0] idx);
        logic res;
        res = 1'b0;
        if (idx < 4'(lrc_pkg::NUM_CELLS)) begin
            res = vec[idx];
        end
        return res;
    endfunction : pick_cell

    logic [9:0] cell_reg;
    logic [9:0] next_cell;
    logic [9:0] fast_in;
    logic [9:0] reg_d;
    logic [9:0] clr_hit;
    logic [9:0] pre_hit;
    logic [9:0] aload_val;
    wire logic dev_rst;
    wire logic link_left_src;
    wire logic local_link;

    // Pin only acts when the build option enables it
    // A parameter, not a port: the choice cannot change at run time
    assign dev_rst = DEV_RESET_EN & ~device_wide_reset_n;

    // Only the left side reaches the clock generator
    assign link_left_src = route_cfg.clkgen_sel ? clkgen_in
                                                : direct_from_left;
    assign local_link = route_cfg.link_from_right ? direct_from_right
                                                  : link_left_src;

    // Cell datapath, one slice per cell; cell 0 is cell one
    genvar i;
    generate
        for (i = 0; i < lrc_pkg::NUM_CELLS; i++) begin : g_cell
            wire logic [3:0] lut_idx;
            wire logic chain_src;
            wire logic regc_src;

            // Top of chain: cluster chain input or a direct link
            if (i == 0) begin : g_top
                assign chain_src = lut_chain_in | local_link;
                assign regc_src = reg_chain_in;
            end else begin : g_mid
                assign chain_src = comb_out[i-1];
                assign regc_src = reg_out[i-1];
            end
            assign fast_in[i] = chain_src;

            // Fast input replaces the fourth data input at the table
            assign lut_idx = {cell_cfg[i].fast_from_chain ? fast_in[i]
                                                          : cell_data[i][3],
                              cell_data[i][2:0]};
            assign comb_out[i] = cell_cfg[i].lut_mask[lut_idx];
            assign reg_d[i] = cell_cfg[i].reg_from_chain ? regc_src
                                                         : comb_out[i];

            // Two shared clears, one shared preset/load line
            assign clr_hit[i] =
                (cell_cfg[i].clr_sel[0] & ctrl.aclr[0]) |
                (cell_cfg[i].clr_sel[1] & ctrl.aclr[1]);
            assign pre_hit[i] = cell_cfg[i].preset_use & ctrl.apre;
            // Preset is a load of a constant one, no inverters
            assign aload_val[i] = cell_cfg[i].aload_data ? cell_data[i][3]
                : lrc_pkg::PRESET_LEVEL;

            // Asynchronous controls act on the output at once; order
            // is chip reset, then clear, then preset or load
            assign reg_out[i] = (dev_rst | clr_hit[i]) ? lrc_pkg::REG_RESET
                : pre_hit[i] ? aload_val[i]
                : cell_reg[i];

            // Next state; asynchronous terms also pin the stored bit so
            // the output does not jump back when they release
            // ena gates only the synchronous terms; sclr wins over sload
            assign next_cell[i] =
                dev_rst ? lrc_pkg::REG_RESET
                : clr_hit[i] ? lrc_pkg::REG_RESET
                : pre_hit[i] ? aload_val[i]
                : ~ctrl.ena ? cell_reg[i]
                : ctrl.sclr ? lrc_pkg::REG_RESET
                : ctrl.sload ? cell_data[i][3]
                : reg_d[i];
        end
    endgenerate

    // Cell storage; rstn is synchronous and only clears the stored bits.
    // The pin and the shared clears reach reg_out through the override
    // above, which trades a mux per cell for flops with plain data input
    always_ff @(posedge clk) begin
        if (!rstn) begin
            cell_reg <= {lrc_pkg::NUM_CELLS{lrc_pkg::REG_RESET}};
        end else begin
            cell_reg <= next_cell;
        end
    end

    // Chains leave from the last cell
    // so a longer chain carries on in the cluster below
    assign lut_chain_out = comb_out[lrc_pkg::NUM_CELLS-1];
    assign reg_chain_out = reg_out[lrc_pkg::NUM_CELLS-1];

    // Direct links into neighbour local routing
    assign direct_left_out = pick_cell(comb_out,
                                       route_cfg.link_left_cell);
    assign direct_right_out = pick_cell(comb_out,
                                        route_cfg.link_right_cell);

    // Cells picked to feed the row and column segments
    wire logic row_own;
    wire logic col_own;
    logic col_val;
    logic row_r;
    logic row_l;
    assign row_own = pick_cell(comb_out, route_cfg.row_cell);
    assign col_own = pick_cell(comb_out, route_cfg.col_cell);

    // Row drivers: each spans ROW_SPAN_CLUSTERS in one direction;
    // rightward takes owner, right neighbour, arriving rightward segment or
    // column; leftward takes owner, left neighbour, arriving leftward or column
    // The default arms only keep the muxes free of latches
    always_comb begin
        case (route_cfg.row_right_src)
            lrc_pkg::ROW_OWN: row_r = row_own;
            lrc_pkg::ROW_NEIGHBOUR: row_r = row_right_nbr;
            lrc_pkg::ROW_EXTEND: row_r = row_right_in;
            lrc_pkg::ROW_FROM_COL: row_r = col_in;
            default: row_r = 1'b0;
        endcase
        case (route_cfg.row_left_src)
            lrc_pkg::ROW_OWN: row_l = row_own;
            lrc_pkg::ROW_NEIGHBOUR: row_l = row_left_nbr;
            lrc_pkg::ROW_EXTEND: row_l = row_left_in;
            lrc_pkg::ROW_FROM_COL: row_l = col_in;
            default: row_l = 1'b0;
        endcase
    end
    assign row_right_out = row_r;
    assign row_left_out = row_l;

    // Column driver: one direction across COL_SPAN_ROWS rows
    // col_down picks which of the two segments carries the value
    always_comb begin
        case (route_cfg.col_src)
            lrc_pkg::COL_OWN: col_val = col_own;
            lrc_pkg::COL_NEIGHBOUR: col_val = col_nbr;
            lrc_pkg::COL_EXTEND: col_val = col_in;
            lrc_pkg::COL_FROM_ROW: col_val = row_right_in;
            default: col_val = 1'b0;
        endcase
    end
    // Idle direction is held low so it never fights another driver
    assign col_up_out = route_cfg.col_down ? 1'b0 : col_val;
    assign col_down_out = route_cfg.col_down ? col_val : 1'b0;

endmodule : lrc_cluster

`default_nettype wire

// ===== sim/lrc_cluster_checker.sv
/* Port assertions for one logic cluster.
   Assumes one clock and rstn active low, synchronous. */
`timescale 1ns/10ps
`default_nettype none
module lrc_cluster_checker #(
    parameter bit DEV_RESET_EN = 1'b1 // Pin enable
) (
    input wire logic clk, // Clock
    input wire logic rstn, // Reset
    input wire logic device_wide_reset_n, // Pin
    input wire lrc_pkg::lrc_ctrl_t ctrl, // Controls
    input wire lrc_pkg::lrc_cell_cfg_t [9:0] cell_cfg, // Cell setup
    input wire lrc_pkg::lrc_route_cfg_t route_cfg, // Routing
    input wire logic [9:0][3:0] cell_data, // Data
    input wire logic row_right_nbr, // Neighbour
    input wire logic [9:0] comb_out, // LUT outputs
    input wire logic [9:0] reg_out, // Registers
    input wire logic lut_chain_out, // Chain out
    input wire logic reg_chain_out, // Chain out
    input wire logic row_right_out, // Row
    input wire logic col_up_out // Column
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    wire logic dev_rst = DEV_RESET_EN && !device_wide_reset_n;
    // Pin reset needs no clock edge, so check in the same cycle
    pin_reset_a: assert property (dev_rst |-> reg_out == '0)
        else $error("pin reset left a register high");
    chain_outs_a: assert property (
        lut_chain_out == comb_out[9] && reg_chain_out == reg_out[9])
        else $error("chain outputs wrong");
    row_nbr_a: assert property (
        route_cfg.row_right_src == lrc_pkg::ROW_NEIGHBOUR
        |-> row_right_out == row_right_nbr) else $error("row source");
    col_idle_a: assert property (route_cfg.col_down |-> !col_up_out)
        else $error("idle column direction driven");
    // Per cell: clear beats preset, preset value, hold and chains
    for (genvar i = 0; i < 10; i++) begin : g_cell
        wire logic clr = |(cell_cfg[i].clr_sel & ctrl.aclr);
        wire logic pre = ctrl.apre && cell_cfg[i].preset_use;
        wire logic quiet = !dev_rst && !clr && !pre;
        clear_wins_a: assert property (clr |-> !reg_out[i])
            else $error("clear did not win");
        preset_val_a: assert property (
            !dev_rst && !clr && pre |-> reg_out[i] ==
            (cell_cfg[i].aload_data ? cell_data[i][3] : 1'b1))
            else $error("preset value wrong");
        hold_off_a: assert property (
            quiet && !ctrl.ena ##1 quiet |-> reg_out[i] == $past(reg_out[i]))
            else $error("register moved with enable low");
        if (i > 0) begin : g_chain
            shift_a: assert property (
                quiet && ctrl.ena && !ctrl.sclr && !ctrl.sload &&
                cell_cfg[i].reg_from_chain ##1 quiet
                |-> reg_out[i] == $past(reg_out[i-1]))
                else $error("register chain did not shift");
            fast_in_a: assert property (cell_cfg[i].fast_from_chain |->
                comb_out[i] == cell_cfg[i].lut_mask[{comb_out[i-1],
                cell_data[i][2:0]}]) else $error("LUT chain wrong");
        end
    end
    cover property (ctrl.apre && |ctrl.aclr);
    cover property (dev_rst && ctrl.apre);
    cover property (reg_chain_out);
endmodule : lrc_cluster_checker
bind lrc_cluster lrc_cluster_checker #(.DEV_RESET_EN(DEV_RESET_EN)) u_chk (
    .clk, .rstn, .device_wide_reset_n, .ctrl, .cell_cfg, .route_cfg,
    .cell_data, .row_right_nbr, .comb_out, .reg_out, .lut_chain_out,
    .reg_chain_out, .row_right_out, .col_up_out);
`default_nettype wire

// ===== sim/lrc_far_model.sv
/* Neighbour clusters, memory and io cells around the cluster.
   Assumes the bench picks the level each neighbour shows. */
`timescale 1ns/10ps
`default_nettype none
module lrc_far_model (
    input wire logic [10:0] pat, // Wanted neighbour levels
    output logic [10:0] far // Into the cluster inputs
);
    // Plain wires: neighbours are static logic levels here
    assign far = pat;
endmodule : lrc_far_model
`default_nettype wire

// ===== sim/lrc_cluster_tb.sv
/* Self-checking bench for one logic cluster.
   Assumes a 125 MHz clock and inputs changed at falling edges. */
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin \
    errors++; $display("[ERR] %s exp %h got %h", n, e, a); end end
module lrc_cluster_tb;
    logic clk = 0, rstn = 0, dev_n = 1;
    lrc_pkg::lrc_ctrl_t ctrl = '0;
    lrc_pkg::lrc_cell_cfg_t [9:0] cfg = '0;
    lrc_pkg::lrc_route_cfg_t rc = '0;
    logic [9:0][3:0] data = '0;
    logic [10:0] pat = '0, far;
    logic lci, rci, dfl, dfr, cgi, rrn, rln, rri, rli, cn, ci;
    logic [9:0] comb, regq, aexp [3];
    logic lco, rco, rro, rlo, cuo, cdo, dlo, dro;
    logic [9:0] regq_off;
    logic [16:0] rows [6];
    int errors = 0, comparisons = 0;
    // Routing rows: sources, column way, neighbours, expected outputs
    initial rows = '{{2'h1, 2'h1, 2'h1, 1'b0, 6'h22, 4'ha},
        {2'h2, 2'h2, 2'h2, 1'b1, 6'h19, 4'h9},
        {2'h3, 2'h3, 2'h3, 1'b0, 6'h0d, 4'he},
        {2'h0, 2'h0, 2'h0, 1'b1, 6'h3f, 4'h0},
        {2'h1, 2'h2, 2'h3, 1'b1, 6'h14, 4'h4},
        {2'h2, 2'h3, 2'h1, 1'b1, 6'h1b, 4'hd}};
    initial aexp = '{10'h3e0, 10'h01f, 10'h3ff};
    assign {lci, rci, dfl, dfr, cgi, rrn, rln, rri, rli, cn, ci} = far;
    always #4 clk = ~clk;
    lrc_far_model u_far (.pat(pat), .far(far));
    lrc_cluster #(.DEV_RESET_EN(1'b1)) DUT (
        .clk(clk), .rstn(rstn), .device_wide_reset_n(dev_n), .ctrl(ctrl),
        .cell_cfg(cfg), .route_cfg(rc), .cell_data(data),
        .lut_chain_in(lci), .reg_chain_in(rci), .direct_from_left(dfl),
        .direct_from_right(dfr), .clkgen_in(cgi), .row_right_nbr(rrn),
        .row_left_nbr(rln), .row_right_in(rri), .row_left_in(rli),
        .col_nbr(cn), .col_in(ci), .comb_out(comb), .reg_out(regq),
        .lut_chain_out(lco), .reg_chain_out(rco), .direct_left_out(dlo),
        .direct_right_out(dro), .row_right_out(rro), .row_left_out(rlo),
        .col_up_out(cuo), .col_down_out(cdo));
    // Same stimulus with the pin option off; only its registers are read
    lrc_cluster #(.DEV_RESET_EN(1'b0)) dut_pin_off (
        .clk(clk), .rstn(rstn), .device_wide_reset_n(dev_n), .ctrl(ctrl),
        .cell_cfg(cfg), .route_cfg(rc), .cell_data(data),
        .lut_chain_in(lci), .reg_chain_in(rci), .direct_from_left(dfl),
        .direct_from_right(dfr), .clkgen_in(cgi), .row_right_nbr(rrn),
        .row_left_nbr(rln), .row_right_in(rri), .row_left_in(rli),
        .col_nbr(cn), .col_in(ci), .comb_out(), .reg_out(regq_off),
        .lut_chain_out(), .reg_chain_out(), .direct_left_out(),
        .direct_right_out(), .row_right_out(), .row_left_out(),
        .col_up_out(), .col_down_out());
    task automatic finish_test();
        if (errors == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : finish_test
    // Hang guard: the whole run is far shorter than this
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        finish_test();
    end
    // Main sequence: table first, then register cases by hand
    initial begin
        repeat (20) @(negedge clk);
        rstn = 1;
        `CHK("reset", 10'h0, regq)
        foreach (rows[k]) begin
            @(negedge clk);
            rc.row_right_src = lrc_pkg::lrc_row_src_t'(rows[k][16:15]);
            rc.row_left_src = lrc_pkg::lrc_row_src_t'(rows[k][14:13]);
            rc.col_src = lrc_pkg::lrc_col_src_t'(rows[k][12:11]);
            rc.col_down = rows[k][10];
            pat[5:0] = rows[k][9:4];
            #1 `CHK("route", rows[k][3:0], ({rro, rlo, cuo, cdo}))
        end
        // Every cell passes bit 3 on, so the chain head shows everywhere
        for (int k = 0; k < 3; k++) begin
            @(negedge clk);
            foreach (cfg[i]) cfg[i] = '{16'hff00, 1'b1, 1'b1,
                i < 5 ? lrc_pkg::CLR_A : lrc_pkg::CLR_B, 1'b1, 1'b0};
            rc.clkgen_sel = (k == 0);
            rc.link_from_right = (k == 2);
            rc.link_left_cell = 4'h9;
            rc.link_right_cell = 4'ha;
            pat[10:6] = 5'b00011;
            #1 `CHK("chain", (k == 1) ? 10'h0 : 10'h3ff, comb)
            `CHK("lut chain out", (k == 1) ? 1'b0 : 1'b1, lco)
            `CHK("links", (k == 1) ? 2'b00 : 2'b10, ({dlo, dro}))
        end
        // Own cell 3 onto the rightward row and column segments, pat[5:0] levels low, direct link from right still high
        @(negedge clk);
        rc.row_right_src = lrc_pkg::ROW_OWN;
        rc.col_src = lrc_pkg::COL_OWN;
        rc.row_cell = 4'h3;
        rc.col_cell = 4'h3;
        pat[5:0] = 6'h00;
        #1 `CHK("own segs", 3'b101, ({rro, rlo, cdo}))
        @(negedge clk);
        ctrl.ena = 1;
        pat[9] = 1;
        @(negedge clk);
        pat[9] = 0;
        repeat (2) @(negedge clk);
        `CHK("shift", 10'h004, regq)
        ctrl.ena = 0;
        repeat (2) @(negedge clk);
        `CHK("hold", 10'h004, regq)
        {ctrl.ena, ctrl.sload, data} = {2'b11, 40'h8000000008};
        @(negedge clk);
        `CHK("sload", 10'h201, regq)
        `CHK("reg chain out", 1'b1, rco)
        // Sync clear is ignored with enable low, then beats the load
        {ctrl.ena, ctrl.sclr} = 2'b01;
        @(negedge clk);
        `CHK("sclr refused", 10'h201, regq)
        ctrl.ena = 1;
        @(negedge clk);
        `CHK("sclr", 10'h000, regq)
        // Without the reset the pending load would bring 201 back
        ctrl.sclr = 0;
        rstn = 0;
        @(negedge clk);
        `CHK("rstn", 10'h0, regq)
        ctrl = '0;
        rstn = 1;
        ctrl.apre = 1;
        // Clear A, clear B, then neither, all with preset held high
        for (int k = 0; k < 3; k++) begin
            @(negedge clk);
            ctrl.aclr = 2'((k + 1) % 3);
            #1 `CHK("aclr", aexp[k], regq)
        end
        @(negedge clk);
        foreach (cfg[i]) cfg[i].aload_data = 1;
        #1 `CHK("aload", 10'h201, regq)
        @(negedge clk);
        dev_n = 0;
        #1 `CHK("pin", 10'h0, regq)
        `CHK("pin disabled", 10'h201, regq_off)
        @(negedge clk);
        {dev_n, ctrl} = {1'b1, 6'h0};
        #1 `CHK("after pin", 10'h0, regq)
        finish_test();
    end
endmodule : lrc_cluster_tb
`default_nettype wire
